// ==== shared/scan_port_pkg.sv ====
// Constants for the scanner channel handshake port.
// Assumes a single 10 MHz clock domain.
package scan_port_pkg;
	localparam int unsigned CLOCK_NS       = 100;
	localparam int unsigned RESPONSE_US    = 60;
	localparam int unsigned RESPONSE_CYC   = (RESPONSE_US * 1000) / CLOCK_NS;
	localparam int unsigned ANALOG_FRAC    = 2;
	localparam int unsigned ANALOG_CYC     = RESPONSE_CYC / ANALOG_FRAC;
	localparam int unsigned CHAN_W         = 8;
	localparam logic [7:0]  CHAN_RESET     = 8'h00;
	localparam int unsigned CNT_W          = 10;
	localparam logic [1:0]  TRIG_MODE_EXT  = 2'h2;
endpackage : scan_port_pkg

// ==== hw/rise_detect.sv ====
// Rising edge detector for a synchronous input.
// Assumes input already synchronous to i_clock.
`timescale 1ns/1ps
module rise_detect (
	input  wire logic i_clock,
	input  wire logic i_nrst,
	input  wire logic i_level,
	output logic      o_rise
);
	logic last;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			last <= 1'b0;
		end else begin
			last <= i_level;
		end
	end

	assign o_rise = i_level & ~last;
endmodule : rise_detect

// ==== hw/scanner_channel_handshake.sv ====
// Device end of the scanner handshake port.
// Assumes all pins are synchronous to i_clock; no software registers.
//
// Overview of operation
// - Channel number is eight select lines, line 7 most significant.
// - All slash signals are active low: low means asserted.
// - Trigger with qualifier low loads channel number, selects correction set.
// - Analog-done strobe goes low when analog part ends, before data ready.
// - Cycle-done strobe goes low when whole measurement finishes.
// - External trigger acts only in outside trigger mode.
// - In outside trigger mode, measurement starts on the external trigger rising edge only.
// - Analog-done strobe responds about 30 us, cycle-done strobe about 60 us after a trigger.
// - With correction disabled, ignore channel inputs, hold strobes low.
`timescale 1ns/1ps
module scanner_channel_handshake (
	input  wire logic       i_clock,
	input  wire logic       i_nrst,
	input  wire logic [7:0] i_channel_select_lines_n,
	input  wire logic       i_channel_qualifier_n,
	input  wire logic       i_outside_trigger_in,
	input  wire logic [1:0] i_trigger_mode,
	input  wire logic       i_correction_on,
	input  wire logic       i_internal_trigger,
	output logic            o_analog_done_strobe_n,
	output logic            o_cycle_done_strobe_n,
	output logic [7:0]      o_correction_set,
	output logic            o_busy
);
	// ------------------------------------------------------------
	// Trigger qualification
	// ------------------------------------------------------------
	logic ext_rise;
	logic trigger;

	rise_detect u_rise (
		.i_clock (i_clock),
		.i_nrst  (i_nrst),
		.i_level (i_outside_trigger_in),
		.o_rise  (ext_rise)
	);

	always_comb begin
		if (i_trigger_mode == scan_port_pkg::TRIG_MODE_EXT) begin
			trigger = ext_rise;
		end else begin
			trigger = i_internal_trigger;
		end
	end

	// ------------------------------------------------------------
	// Measurement sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		IDLE   = 3'b001,
		ANALOG = 3'b010,
		FINISH = 3'b100
	} seq_t;

	seq_t                             state;
	logic [scan_port_pkg::CNT_W-1:0] count;
	logic                             start;

	assign start = trigger & (state != ANALOG) & (state != FINISH);
	assign o_busy = (state != IDLE);

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			state <= IDLE;
			count <= '0;
		end else begin
			case (state)
				IDLE: begin
					if (start) begin
						state <= ANALOG;
						count <= '0;
					end
				end
				ANALOG: begin
					count <= count + 1'b1;
					if (count == scan_port_pkg::CNT_W'(scan_port_pkg::ANALOG_CYC - 1)) begin
						state <= FINISH;
					end
				end
				FINISH: begin
					count <= count + 1'b1;
					if (count == scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC - 1)) begin
						state <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Channel capture
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_correction_set <= scan_port_pkg::CHAN_RESET;
		end else if (start && i_correction_on && !i_channel_qualifier_n) begin
			o_correction_set <= ~i_channel_select_lines_n;
		end
	end

	// ------------------------------------------------------------
	// Completion strobes: high from an accepted trigger, low when their own part is done
	// ------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_analog_done_strobe_n <= 1'b0;
		end else if (!i_correction_on) begin
			o_analog_done_strobe_n <= 1'b0;
		end else if (start) begin
			o_analog_done_strobe_n <= 1'b1;
		end else if (state == ANALOG &&
			count == scan_port_pkg::CNT_W'(scan_port_pkg::ANALOG_CYC - 1)) begin
			o_analog_done_strobe_n <= 1'b0;
		end
	end

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			o_cycle_done_strobe_n <= 1'b0;
		end else if (!i_correction_on) begin
			o_cycle_done_strobe_n <= 1'b0;
		end else if (start) begin
			o_cycle_done_strobe_n <= 1'b1;
		end else if (state == FINISH &&
			count == scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC - 1)) begin
			o_cycle_done_strobe_n <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Response watch: cycles since an accepted trigger
	// ------------------------------------------------------------
	logic [scan_port_pkg::CNT_W-1:0] since_start;

	always_ff @(posedge i_clock or negedge i_nrst) begin
		if (!i_nrst) begin
			since_start <= '0;
		end else if (!i_correction_on) begin
			since_start <= '0; // Strobes are forced low, nothing to time
		end else if (start) begin
			since_start <= scan_port_pkg::CNT_W'(1);
		end else if (since_start ==
			scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC + 1)) begin
			since_start <= '0;
		end else if (since_start != '0) begin
			since_start <= since_start + 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	ext_mode_gate_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_trigger_mode != scan_port_pkg::TRIG_MODE_EXT && !i_internal_trigger && state == IDLE)
		|=> state == IDLE)
		else $error("start without trigger in current mode");

	rise_start_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_trigger_mode == scan_port_pkg::TRIG_MODE_EXT && state == IDLE &&
		 i_outside_trigger_in && !$past(i_outside_trigger_in)) |=> state == ANALOG)
		else $error("rising edge did not start a measurement");

	no_level_start_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_trigger_mode == scan_port_pkg::TRIG_MODE_EXT && state == IDLE &&
		 $past(i_outside_trigger_in)) |=> state == IDLE)
		else $error("start on a level rather than an edge");

	chan_load_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(start && i_correction_on && !i_channel_qualifier_n)
		|=> o_correction_set == ~$past(i_channel_select_lines_n))
		else $error("channel not loaded on trigger");

	chan_ignore_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(!i_correction_on || i_channel_qualifier_n) |=> $stable(o_correction_set))
		else $error("channel changed while ignored");

	strobes_low_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		!$past(i_correction_on) |-> (!o_analog_done_strobe_n && !o_cycle_done_strobe_n))
		else $error("strobes not held low with correction off");

	analog_first_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_correction_on && !o_cycle_done_strobe_n) |-> !o_analog_done_strobe_n)
		else $error("cycle done before analog done");

	response_time_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		since_start == scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC + 1)
		|-> !o_cycle_done_strobe_n)
		else $error("cycle done not seen 60 us after trigger");

	analog_time_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		since_start == scan_port_pkg::CNT_W'(scan_port_pkg::ANALOG_CYC + 1)
		|-> !o_analog_done_strobe_n)
		else $error("analog done not seen at its time");

	analog_wait_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(since_start != '0 &&
		 since_start <= scan_port_pkg::CNT_W'(scan_port_pkg::ANALOG_CYC)) |-> o_analog_done_strobe_n)
		else $error("analog done came early");

	cycle_wait_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(since_start != '0 &&
		 since_start <= scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC)) |-> o_cycle_done_strobe_n)
		else $error("cycle done came early");

	busy_span_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(since_start != '0 &&
		 since_start <= scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC)) |-> o_busy)
		else $error("busy dropped during a measurement");

	busy_end_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		since_start == scan_port_pkg::CNT_W'(scan_port_pkg::RESPONSE_CYC + 1)
		|-> !o_busy)
		else $error("busy still high after the response time");

	int_ignore_a: assert property (@(posedge i_clock) disable iff (!i_nrst)
		(i_trigger_mode == scan_port_pkg::TRIG_MODE_EXT && state == IDLE && !i_outside_trigger_in)
		|=> state == IDLE)
		else $error("internal trigger acted in outside trigger mode");
endmodule : scanner_channel_handshake

// ==== tb/scan_ctrl_model.sv ====
// Scanner controller model: sets channel, qualifier, then one trigger pulse.
// Assumes i_go and i_swap are one-cycle pulses given while the model is idle.
`timescale 1ns/1ps
module scan_ctrl_model (
	input  wire logic       i_clock,
	input  wire logic       i_go,
	input  wire logic       i_swap,
	input  wire logic       i_use_qual,
	input  wire logic [7:0] i_chan,
	output logic [7:0]      o_lines_n = 8'hff,
	output logic            o_qual_n = 1'h1,
	output logic            o_trig = 1'h0
);
	int step = 0;
	always @(posedge i_clock) begin
		step <= i_go ? 1 : (step == 0 || step == 15) ? 0 : step + 1;
		case (step)
			1: o_qual_n <= 1'h1;
			2: o_lines_n <= ~i_chan;
			3: o_qual_n <= ~i_use_qual;
			4: o_trig <= 1'h1;
			14: o_trig <= 1'h0;
			default: if (i_swap) o_lines_n <= ~i_chan;
		endcase
	end
endmodule : scan_ctrl_model

// ==== tb/tb_scanner_channel_handshake.sv ====
// Bench for the scanner handshake port, random and corner channel numbers.
// Assumes a 600-cycle measurement, analog part ending at cycle 300.
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s: expected %h, seen %h", n, e, g); end end
module tb_scanner_channel_handshake;
	logic       i_clock = 1'h0, i_nrst = 1'h0, go = 1'h0, use_qual = 1'h1, swap = 1'h0;
	logic       corr = 1'h1, int_trig = 1'h0, qual_n, trig, analog_n, cycle_n, busy;
	logic [1:0] mode = 2'h2;
	logic [7:0] chan = 8'h00, r = 8'h00, lines_n, cset;
	int         num_errors = 0, n_compared = 0, k;
	scan_ctrl_model ctrl (.i_clock(i_clock), .i_go(go), .i_swap(swap), .i_use_qual(use_qual),
		.i_chan(chan), .o_lines_n(lines_n), .o_qual_n(qual_n), .o_trig(trig));
	scanner_channel_handshake uut (.i_clock(i_clock), .i_nrst(i_nrst),
		.i_channel_select_lines_n(lines_n), .i_channel_qualifier_n(qual_n),
		.i_outside_trigger_in(trig), .i_trigger_mode(mode), .i_correction_on(corr),
		.i_internal_trigger(int_trig), .o_analog_done_strobe_n(analog_n),
		.o_cycle_done_strobe_n(cycle_n), .o_correction_set(cset), .o_busy(busy));
	initial forever #50 i_clock = ~i_clock;
	task automatic end_of_test;
		$display("errors %0d, compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : end_of_test
	task automatic run(input logic [7:0] ch, input logic q, input logic c,
		input logic [7:0] exp_set, input logic internal);
		@(posedge i_clock);
		corr <= c;
		use_qual <= q;
		chan <= ch;
		if (internal) int_trig <= 1'h1;
		else go <= 1'h1;
		@(posedge i_clock);
		go <= 1'h0;
		int_trig <= 1'h0;
		k = 0;
		while (busy !== 1'h1 && k < 40) begin
			@(negedge i_clock);
			k++;
		end
		`CHK("busy", 1'h1, busy)
		repeat (299) @(negedge i_clock);
		`CHK("analog early", c, analog_n)
		@(negedge i_clock);
		`CHK("analog", 1'h0, analog_n)
		`CHK("cycle pending", c, cycle_n)
		@(posedge i_clock);
		chan <= ~ch;
		swap <= 1'h1;
		@(posedge i_clock);
		swap <= 1'h0;
		repeat (299) @(negedge i_clock);
		`CHK("cycle", 1'h0, cycle_n)
		`CHK("busy end", 1'h0, busy)
		`CHK("set", exp_set, cset)
	endtask : run
	initial begin
		k = $urandom(32'hf7f1dfcd);
		repeat (5) @(posedge i_clock);
		i_nrst <= 1'h1;
		run(8'h80, 1'h1, 1'h1, 8'h80, 1'h0);
		run(8'hff, 1'h1, 1'h1, 8'hff, 1'h0);
		run(8'h01, 1'h1, 1'h1, 8'h01, 1'h0);
		for (int i = 0; i < 3; i++) begin
			r = 8'($urandom);
			run(r, 1'h1, 1'h1, r, 1'h0);
		end
		run(8'h5a, 1'h0, 1'h1, r, 1'h0);
		run(8'h3c, 1'h1, 1'h0, r, 1'h0);
		@(posedge i_clock);
		int_trig <= 1'h1;
		@(posedge i_clock);
		int_trig <= 1'h0;
		repeat (3) @(negedge i_clock);
		`CHK("internal in ext mode", 1'h0, busy)
		@(posedge i_clock);
		mode <= 2'h0;
		chan <= 8'h21;
		go <= 1'h1;
		@(posedge i_clock);
		go <= 1'h0;
		repeat (40) @(negedge i_clock);
		`CHK("ignored trigger", 1'h0, busy)
		run(8'h21, 1'h1, 1'h1, 8'h21, 1'h1);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge i_clock);
		num_errors++;
		end_of_test();
	end
endmodule : tb_scanner_channel_handshake
